// file: hdl/flash_link_front.sv
/*
 * serial link front end on the host clock: shifts in opcode, address and
 * data, and shifts status bytes out on reads.
 * assumes sclk stands still while csN is high and that the status and flag
 * snapshots are frozen by the system side for the whole frame.
 */
`timescale 1ns/10ps
module flash_link_front (
	input wire logic sclk, // host serial clock
	input wire logic csN, // chip select, active low
	input wire logic mosi, // serial data in
	input wire logic [7:0] statusSnap, // frozen protection status
	input wire logic [7:0] flagSnap, // frozen flag status
	output logic miso, // serial data out
	output logic misoEn, // drive enable for miso
	output logic [7:0] cmdWord, // captured opcode
	output logic [23:0] addrWord, // captured address
	output logic [7:0] dataWord, // first data byte after opcode
	output logic [5:0] frameBits // edges seen in the frame, saturating
);

	typedef struct packed {
		logic [5:0] bitCount;
		logic [2:0] readPhase;
		logic readMode;
		logic [7:0] readByte;
		logic miso;
		logic misoEn;
	} frame_state_t;

	typedef struct packed {
		logic [31:0] shiftIn;
		logic [7:0] cmd;
		logic [23:0] addr;
		logic [7:0] data;
		logic [5:0] bits;
	} word_state_t;

	frame_state_t frame_reg, frame_next;
	word_state_t words_reg, words_next;
	logic [7:0] incoming;
	logic [7:0] snap;

	// byte completing on this edge and the snapshot it selects
	assign incoming = {words_reg.shiftIn[6:0], mosi};
	assign snap = (incoming == flash_protect_pkg::CMD_FLAG_READ) ? flagSnap : statusSnap;

	// frame counting and read shifting, emptied by the frame's own select
	always_comb begin
		frame_next = frame_reg;
		if (frame_reg.bitCount != flash_protect_pkg::BITS_SATURATE) begin
			frame_next.bitCount = frame_reg.bitCount + 6'h01;
		end
		if (frame_reg.bitCount == flash_protect_pkg::BITS_OPCODE - 6'h01) begin
			if (incoming == flash_protect_pkg::CMD_STATUS_READ ||
				incoming == flash_protect_pkg::CMD_FLAG_READ) begin
				frame_next.readMode = 1'b1;
				frame_next.readByte = snap;
				frame_next.miso = snap[7];
				frame_next.misoEn = 1'b1;
				frame_next.readPhase = 3'h1;
			end
		end else if (frame_reg.readMode) begin
			// byte repeats for as long as the host keeps clocking
			frame_next.miso = frame_reg.readByte[3'h7 - frame_reg.readPhase];
			frame_next.readPhase = frame_reg.readPhase + 3'h1;
		end
	end

	// frame state clears asynchronously to a constant when select rises
	always_ff @(posedge sclk or posedge csN) begin
		if (csN) begin
			frame_reg <= '0;
		end else begin
			frame_reg <= frame_next;
		end
	end

	// captured words survive the end of the frame for the system side
	always_comb begin
		words_next = words_reg;
		words_next.shiftIn = {words_reg.shiftIn[30:0], mosi};
		words_next.bits = frame_reg.bitCount + 6'h01;
		if (frame_reg.bitCount == flash_protect_pkg::BITS_SATURATE) begin
			words_next.bits = flash_protect_pkg::BITS_SATURATE;
		end
		if (frame_reg.bitCount == flash_protect_pkg::BITS_OPCODE - 6'h01) begin
			words_next.cmd = incoming;
		end
		if (frame_reg.bitCount == flash_protect_pkg::BITS_STATUS_WRITE - 6'h01) begin
			words_next.data = incoming;
		end
		if (frame_reg.bitCount == flash_protect_pkg::BITS_ADDRESSED - 6'h01) begin
			words_next.addr = {words_reg.shiftIn[22:0], mosi};
		end
	end

	// word registers
	always_ff @(posedge sclk) begin
		words_reg <= words_next;
	end

	assign miso = frame_reg.miso;
	assign misoEn = frame_reg.misoEn;
	assign cmdWord = words_reg.cmd;
	assign addrWord = words_reg.addr;
	assign dataWord = words_reg.data;
	assign frameBits = words_reg.bits;

endmodule

// file: hdl/flash_protect_pkg.sv
/*
 * shared constants for the status and block-protection logic of a serial
 * nor flash: command codes, status field positions, array geometry,
 * busy timings and the phase encoding.
 * assumes a 250 MHz system clock and a host-driven serial clock.
 */
package flash_protect_pkg;

	// system clock
	localparam int CLK_PERIOD_NS = 4;

	// command codes seen on the serial link
	localparam logic [7:0] CMD_LATCH_SET = 8'h06;
	localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_FLAG_READ = 8'h70;
	localparam logic [7:0] CMD_FLAG_CLEAR = 8'h50;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
	localparam logic [7:0] CMD_SUB32_ERASE = 8'h52;
	localparam logic [7:0] CMD_SUB4_ERASE = 8'h20;
	localparam logic [7:0] whole_array_erase_command = 8'hc7;

	// frame lengths in link clock edges
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_STATUS_WRITE = 6'h10;
	localparam logic [5:0] BITS_ADDRESSED = 6'h20;
	localparam logic [5:0] BITS_PROGRAM_MIN = 6'h28;
	localparam logic [5:0] BITS_SATURATE = 6'h3f;

	// protection status field positions
	localparam int ST_LOCK_BIT = 7;
	localparam int ST_BP3_BIT = 6;
	localparam int ST_BOTTOM_BIT = 5;
	localparam int ST_BP_LO_MSB = 4;
	localparam int ST_BP_LO_LSB = 2;
	localparam int ST_WEL_BIT = 1;
	localparam int ST_WIP_BIT = 0;

	// flag status field positions
	localparam int FL_READY_BIT = 7;
	localparam int FL_ERASE_ERR_BIT = 5;
	localparam int FL_PROG_ERR_BIT = 4;
	localparam int FL_PROT_ERR_BIT = 1;

	// reset values of the nonvolatile controls
	localparam logic LOCK_RESET = 1'b0;
	localparam logic BOTTOM_RESET = 1'b0;
	localparam logic [3:0] BP_RESET = 4'h0;

	// array geometry: 64KB sectors taken from address bits 23:16
	localparam int ADDR_W = 24;
	localparam int SECTOR_MSB = 23;
	localparam int SECTOR_LSB = 16;
	localparam logic [8:0] SECTOR_COUNT = 9'h100;
	localparam logic [3:0] BP_ALL_FROM = 4'h9;

	// busy times of the internal cycles
	localparam int T_STATUS_WRITE_NS = 400;
	localparam int T_PROGRAM_NS = 800;
	localparam int T_ERASE_NS = 1600;
	localparam logic [15:0] CYC_STATUS_WRITE =
		16'((T_STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_PROGRAM = 16'((T_PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] CYC_ERASE = 16'((T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// internal cycle phase
	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_STATUS_WRITE = 3'b010,
		PH_ARRAY_OP = 3'b100
	} phase_t;

endpackage

// file: hdl/serial_flash_status_protect.sv
/*
 * protection status register, flag status and block-protection decode of a
 * serial nor flash, with the serial link front end instantiated inside.
 * assumes the host clocks sclk only while csN is low and keeps sclk still
 * for at least four system clocks after csN rises; wpN is a raw pin.
 */
// Summary of operation
// - status read and written only by commands
// - lock bit plus low pin blocks status write
// - only a high pin releases the lock
// - bit 7 lock control, default permits writes
// - bit 5 picks top or bottom anchor
// - block-protect bits reject writes to range
// - top anchored ranges grow downward from 255
// - bottom anchored ranges grow upward from 0
// - write latch needed, cleared at power-up
// - bit 0 busy during internal cycles
// - whole-array erase only with zero protect bits
// - busy bit inverse of flag ready bit
// - sixteen megabyte array of 256 sectors
// - flag ready bit low while busy
// - protection error sticky until flag clear
`timescale 1ns/10ps
module serial_flash_status_protect (
	input wire logic clk, // system clock, 250 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic sclk, // host serial clock
	input wire logic csN, // chip select, active low
	input wire logic mosi, // serial data from host
	input wire logic wpN, // write-protect pin, active low
	output logic miso, // serial data to host
	output logic misoEn, // miso drive enable
	output logic writeInProgress, // internal cycle running
	output logic statusLocked, // status writes refused by pin
	output logic protectionError // sticky protection error flag
);

	typedef struct packed {
		logic [2:0] csPipe;
		logic csHigh;
		logic [2:0] wpPipe;
		logic wpHigh;
		logic lockBit;
		logic bottomSel;
		logic [3:0] blockProtectBits;
		logic wel;
		flash_protect_pkg::phase_t phase;
		logic [15:0] busyCnt;
		logic [7:0] pendStatus;
		logic eraseErr;
		logic progErr;
		logic protErr;
		logic [7:0] statusOut;
		logic [7:0] flagOut;
		logic busyOut;
		logic lockOut;
		logic protErrOut;
	} main_state_t;

	main_state_t s_reg, s_next;
	logic [7:0] cmdWord;
	logic [23:0] addrWord;
	logic [7:0] dataWord;
	logic [5:0] frameBits;
	logic frameEnd;
	logic isArrayOp;
	logic isEraseOp;
	logic frameOk;
	logic targetProtected;
	logic wip;
	logic arrayAttempt;

	// does the block-protect code cover this 64KB sector
	function automatic logic sector_protected(input logic bottom, input logic [3:0] bp,
		input logic [7:0] sector);
		logic [8:0] span;
		logic hit;
		span = 9'h000;
		hit = 1'b0;
		if (bp >= flash_protect_pkg::BP_ALL_FROM) begin
			hit = 1'b1;
		end else if (bp != 4'h0) begin
			span = 9'h001 << (bp - 4'h1);
			if (bottom) begin
				hit = {1'b0, sector} < span;
			end else begin
				hit = {1'b0, sector} >= (flash_protect_pkg::SECTOR_COUNT - span);
			end
		end
		return hit;
	endfunction

	flash_link_front link (
		.sclk(sclk),
		.csN(csN),
		.mosi(mosi),
		.statusSnap(s_reg.statusOut),
		.flagSnap(s_reg.flagOut),
		.miso(miso),
		.misoEn(misoEn),
		.cmdWord(cmdWord),
		.addrWord(addrWord),
		.dataWord(dataWord),
		.frameBits(frameBits)
	);

	// frame end seen after filtering; link words are frozen by then
	assign frameEnd = s_next.csHigh && !s_reg.csHigh;
	assign isEraseOp = (cmdWord == flash_protect_pkg::CMD_SECTOR_ERASE) ||
		(cmdWord == flash_protect_pkg::CMD_SUB32_ERASE) ||
		(cmdWord == flash_protect_pkg::CMD_SUB4_ERASE);
	assign isArrayOp = isEraseOp || (cmdWord == flash_protect_pkg::CMD_PAGE_PROGRAM);
	assign frameOk = (cmdWord == flash_protect_pkg::CMD_PAGE_PROGRAM) ?
		(frameBits >= flash_protect_pkg::BITS_PROGRAM_MIN) :
		(frameBits == flash_protect_pkg::BITS_ADDRESSED);
	assign targetProtected = sector_protected(s_reg.bottomSel, s_reg.blockProtectBits,
		addrWord[flash_protect_pkg::SECTOR_MSB:flash_protect_pkg::SECTOR_LSB]);
	assign wip = (s_next.phase != flash_protect_pkg::PH_IDLE);

	// next state: pin filters, command execution, busy timing, snapshots
	always_comb begin
		s_next = s_reg;
		// three-flop filters on the select and write-protect pins
		s_next.csPipe = {s_reg.csPipe[1:0], csN};
		if (s_reg.csPipe[1] == s_reg.csPipe[2]) begin
			s_next.csHigh = s_reg.csPipe[2];
		end
		s_next.wpPipe = {s_reg.wpPipe[1:0], wpN};
		if (s_reg.wpPipe[1] == s_reg.wpPipe[2]) begin
			s_next.wpHigh = s_reg.wpPipe[2];
		end

		// running internal cycle counts down and finishes here
		if (s_reg.phase != flash_protect_pkg::PH_IDLE) begin
			s_next.busyCnt = s_reg.busyCnt - 16'h0001;
			if (s_reg.busyCnt == 16'h0001) begin
				if (s_reg.phase == flash_protect_pkg::PH_STATUS_WRITE) begin
					s_next.lockBit = s_reg.pendStatus[flash_protect_pkg::ST_LOCK_BIT];
					s_next.bottomSel = s_reg.pendStatus[flash_protect_pkg::ST_BOTTOM_BIT];
					s_next.blockProtectBits = {s_reg.pendStatus[flash_protect_pkg::ST_BP3_BIT],
						s_reg.pendStatus[flash_protect_pkg::ST_BP_LO_MSB:
						flash_protect_pkg::ST_BP_LO_LSB]};
				end
				s_next.wel = 1'b0;
				s_next.phase = flash_protect_pkg::PH_IDLE;
			end
		end

		// commands take effect when the frame ends; reads need no action here
		if (frameEnd) begin
			if (cmdWord == flash_protect_pkg::CMD_FLAG_CLEAR &&
				frameBits == flash_protect_pkg::BITS_OPCODE) begin
				s_next.eraseErr = 1'b0;
				s_next.progErr = 1'b0;
				s_next.protErr = 1'b0;
			end
			if (s_reg.phase == flash_protect_pkg::PH_IDLE) begin
				if (cmdWord == flash_protect_pkg::CMD_LATCH_SET &&
					frameBits == flash_protect_pkg::BITS_OPCODE) begin
					s_next.wel = 1'b1;
				end else if (cmdWord == flash_protect_pkg::CMD_LATCH_CLEAR &&
					frameBits == flash_protect_pkg::BITS_OPCODE) begin
					s_next.wel = 1'b0;
				end else if (cmdWord == flash_protect_pkg::CMD_STATUS_WRITE &&
					frameBits == flash_protect_pkg::BITS_STATUS_WRITE && s_reg.wel) begin
					if (s_reg.lockBit && !s_reg.wpHigh) begin
						s_next.wel = 1'b0;
					end else begin
						s_next.phase = flash_protect_pkg::PH_STATUS_WRITE;
						s_next.busyCnt = flash_protect_pkg::CYC_STATUS_WRITE;
						s_next.pendStatus = dataWord;
					end
				end else if (isArrayOp && frameOk && s_reg.wel) begin
					if (targetProtected) begin
						s_next.protErr = 1'b1;
						s_next.eraseErr = isEraseOp;
						s_next.progErr = !isEraseOp;
						s_next.wel = 1'b0;
					end else begin
						s_next.phase = flash_protect_pkg::PH_ARRAY_OP;
						s_next.busyCnt = isEraseOp ? flash_protect_pkg::CYC_ERASE :
							flash_protect_pkg::CYC_PROGRAM;
					end
				end else if (cmdWord == flash_protect_pkg::whole_array_erase_command &&
					frameBits == flash_protect_pkg::BITS_OPCODE && s_reg.wel) begin
					if (s_reg.blockProtectBits != 4'h0) begin
						s_next.wel = 1'b0;
					end else begin
						s_next.phase = flash_protect_pkg::PH_ARRAY_OP;
						s_next.busyCnt = flash_protect_pkg::CYC_ERASE;
					end
				end
			end
		end

		// snapshots for the link change only between frames
		if (s_next.csHigh) begin
			s_next.statusOut = {s_next.lockBit, s_next.blockProtectBits[3], s_next.bottomSel,
				s_next.blockProtectBits[2:0], s_next.wel, wip};
			s_next.flagOut = 8'h00;
			s_next.flagOut[flash_protect_pkg::FL_READY_BIT] = !wip;
			s_next.flagOut[flash_protect_pkg::FL_ERASE_ERR_BIT] = s_next.eraseErr;
			s_next.flagOut[flash_protect_pkg::FL_PROG_ERR_BIT] = s_next.progErr;
			s_next.flagOut[flash_protect_pkg::FL_PROT_ERR_BIT] = s_next.protErr;
		end
		s_next.busyOut = wip;
		s_next.lockOut = s_next.lockBit && !s_next.wpHigh;
		s_next.protErrOut = s_next.protErr;
	end

	// state register; reset stands for power-up
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.csPipe <= 3'h7;
			s_reg.csHigh <= 1'b1;
			s_reg.wpPipe <= 3'h7;
			s_reg.wpHigh <= 1'b1;
			s_reg.lockBit <= flash_protect_pkg::LOCK_RESET;
			s_reg.bottomSel <= flash_protect_pkg::BOTTOM_RESET;
			s_reg.blockProtectBits <= flash_protect_pkg::BP_RESET;
			s_reg.wel <= 1'b0;
			s_reg.phase <= flash_protect_pkg::PH_IDLE;
			s_reg.flagOut <= 8'h80;
		end else begin
			s_reg <= s_next;
		end
	end

	assign writeInProgress = s_reg.busyOut;
	assign statusLocked = s_reg.lockOut;
	assign protectionError = s_reg.protErrOut;

	// checks on the protection behaviour, all on the system clock
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// a program or erase frame that is up for decision this cycle
	assign arrayAttempt = frameEnd && s_reg.wel && isArrayOp && frameOk &&
		s_reg.phase == flash_protect_pkg::PH_IDLE;

	// both views of the busy state come from one snapshot
	a_busy_ready_inverse: assert property (
		s_reg.flagOut[flash_protect_pkg::FL_READY_BIT] ==
		!s_reg.statusOut[flash_protect_pkg::ST_WIP_BIT])
		else $error("busy bit and ready bit disagree");

	// between frames the ready bit follows the running cycle
	a_flag_ready_low: assert property (
		s_reg.csHigh && s_reg.phase != flash_protect_pkg::PH_IDLE
		|-> !s_reg.flagOut[flash_protect_pkg::FL_READY_BIT])
		else $error("ready bit high during cycle");

	// a locked status write loads nothing and drops the latch
	a_locked_write_refused: assert property (
		frameEnd && s_reg.phase == flash_protect_pkg::PH_IDLE &&
		cmdWord == flash_protect_pkg::CMD_STATUS_WRITE &&
		frameBits == flash_protect_pkg::BITS_STATUS_WRITE &&
		s_reg.lockBit && !s_reg.wpHigh
		|=> s_reg.phase == flash_protect_pkg::PH_IDLE && !s_reg.wel)
		else $error("status write ran while hardware locked");

	// only a high pin lifts the lock; no command can
	a_pin_low_holds: assert property (
		s_reg.lockBit && !s_reg.wpHigh && s_reg.phase == flash_protect_pkg::PH_IDLE
		|=> s_reg.lockBit ##1 s_reg.lockBit)
		else $error("lock released while pin low");

	// no internal cycle starts while the write latch is clear
	a_latch_required: assert property (
		s_reg.phase == flash_protect_pkg::PH_IDLE && !s_reg.wel
		|=> s_reg.phase == flash_protect_pkg::PH_IDLE)
		else $error("internal cycle started without write latch");

	// whole-array erase refused while any protect bit is set
	a_whole_erase_blocked: assert property (
		frameEnd && s_reg.wel && s_reg.phase == flash_protect_pkg::PH_IDLE &&
		cmdWord == flash_protect_pkg::whole_array_erase_command &&
		s_reg.blockProtectBits != 4'h0 |=> s_reg.phase == flash_protect_pkg::PH_IDLE)
		else $error("whole-array erase ran with protect bits set");

	// a protected target raises the sticky error and its output
	a_protect_error_set: assert property (
		arrayAttempt && targetProtected |=> s_reg.protErr ##1 s_reg.protErrOut)
		else $error("protected access did not raise error");

	// the error stays until a frame ends
	a_error_sticky: assert property (
		s_reg.protErr && !frameEnd |=> s_reg.protErr)
		else $error("protection error dropped by itself");

	// a flag clear frame empties the error and its output together
	a_error_cleared: assert property (
		frameEnd && cmdWord == flash_protect_pkg::CMD_FLAG_CLEAR &&
		frameBits == flash_protect_pkg::BITS_OPCODE
		|=> !s_reg.protErr && !s_reg.protErrOut)
		else $error("protection error kept after clear");

	// top anchor, code 1000: the lower half stays open
	a_top_half_open: assert property (
		arrayAttempt && isEraseOp && !s_reg.bottomSel && s_reg.blockProtectBits == 4'h8 &&
		!addrWord[flash_protect_pkg::SECTOR_MSB]
		|=> s_reg.phase == flash_protect_pkg::PH_ARRAY_OP ##1 s_reg.busyOut)
		else $error("top anchored range too wide");

	// bottom anchor, code 1000: the upper half stays open
	a_bottom_half_open: assert property (
		arrayAttempt && isEraseOp && s_reg.bottomSel && s_reg.blockProtectBits == 4'h8 &&
		addrWord[flash_protect_pkg::SECTOR_MSB]
		|=> s_reg.phase == flash_protect_pkg::PH_ARRAY_OP)
		else $error("bottom anchored range too wide");

	// code 0001 from the top guards the last sector
	a_top_last_sector: assert property (
		arrayAttempt && !s_reg.bottomSel && s_reg.blockProtectBits == 4'h1 &&
		addrWord[flash_protect_pkg::SECTOR_MSB:flash_protect_pkg::SECTOR_LSB] == 8'hff
		|=> s_reg.protErr)
		else $error("last sector left open");

	// code 0001 from the bottom guards the first sector
	a_bottom_first_sector: assert property (
		arrayAttempt && s_reg.bottomSel && s_reg.blockProtectBits == 4'h1 &&
		addrWord[flash_protect_pkg::SECTOR_MSB:flash_protect_pkg::SECTOR_LSB] == 8'h00
		|=> s_reg.protErr)
		else $error("first sector left open");

	// codes nine and up close the whole array from either anchor
	a_full_range_hit: assert property (
		arrayAttempt && s_reg.blockProtectBits >= flash_protect_pkg::BP_ALL_FROM
		|=> s_reg.protErr && s_reg.phase == flash_protect_pkg::PH_IDLE)
		else $error("full protection let an access through");

	// code 0000 leaves every sector open
	a_none_protected: assert property (
		arrayAttempt && s_reg.blockProtectBits == 4'h0
		|=> s_reg.phase == flash_protect_pkg::PH_ARRAY_OP)
		else $error("unprotected access refused");

	// a finished status write loads the lock, anchor and top protect bit
	a_controls_loaded: assert property (
		s_reg.phase == flash_protect_pkg::PH_STATUS_WRITE && s_reg.busyCnt == 16'h0001
		|=> s_reg.lockBit == s_reg.pendStatus[flash_protect_pkg::ST_LOCK_BIT]
		&& s_reg.bottomSel == s_reg.pendStatus[flash_protect_pkg::ST_BOTTOM_BIT]
		&& s_reg.blockProtectBits[3] == s_reg.pendStatus[flash_protect_pkg::ST_BP3_BIT])
		else $error("status controls not loaded");

	// the latch drops as any internal cycle ends
	a_latch_done_clear: assert property (
		s_reg.phase != flash_protect_pkg::PH_IDLE && s_reg.busyCnt == 16'h0001
		|=> !s_reg.wel && s_reg.phase == flash_protect_pkg::PH_IDLE)
		else $error("write latch kept after cycle end");

	// busy shows on the output and in the status snapshot
	a_busy_visible: assert property (
		s_reg.phase != flash_protect_pkg::PH_IDLE |-> s_reg.busyOut &&
		(!s_reg.csHigh || s_reg.statusOut[flash_protect_pkg::ST_WIP_BIT]))
		else $error("busy output missing during cycle");

	// main scenarios

	c_status_write: cover property (s_reg.phase == flash_protect_pkg::PH_STATUS_WRITE);
	c_protect_hit: cover property ($rose(s_reg.protErr));
	c_array_op: cover property (s_reg.phase == flash_protect_pkg::PH_ARRAY_OP);
	c_locked_refusal: cover property (frameEnd && s_reg.lockBit && !s_reg.wpHigh &&
		cmdWord == flash_protect_pkg::CMD_STATUS_WRITE);

endmodule

// file: testbench/flash_host_model.sv
/*
 * host side of the serial link: clocks whole frames, msb first, and
 * collects the byte returned after the opcode of a read.
 * assumes the caller leaves each frame's command time to act before the next.
 */
`timescale 1ns/10ps
module flash_host_model (
	output logic sclk, // serial clock, still between frames
	output logic csN, // chip select, active low
	output logic mosi, // serial data to the device
	input wire logic miso, // serial data from the device
	input wire logic misoEn // device drive enable
);
	localparam realtime HALF = 80.0;

	// idle levels before the first frame
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
	end

	// one frame of n bits taken from the top of bits; rd is filled after bit 8
	task automatic xfer(input logic [39:0] bits, input int n, output logic [7:0] rd);
		rd = 8'h00;
		csN = 1'b0; // only command frames reach the register
		for (int i = 0; i < n; i++) begin
			mosi = bits[39 - i];
			#HALF;
			if (i >= 8) begin
				rd = {rd[6:0], (misoEn === 1'b1) ? miso : 1'bx};
			end
			sclk = 1'b1;
			#HALF;
			sclk = 1'b0;
		end
		csN = 1'b1;
		mosi = ~mosi; // released line shows no stale bit
		#40; // select stays high well past the pin filter
	endtask
endmodule

// file: testbench/serial_flash_status_protect_bench.sv
/*
 * self-checking bench for the status and block-protection logic: status
 * writes, pin lock, every protect code against erase targets, whole erase.
 * assumes the host model drives the link and the package constants.
 */
`timescale 1ns/10ps
module serial_flash_status_protect_bench;
	logic clk;
	logic rst;
	logic wpN;
	logic sclk;
	logic csN;
	logic mosi;
	logic miso;
	logic misoEn;
	logic writeInProgress;
	logic statusLocked;
	logic protectionError;
	int failCount;
	int checksDone;
	logic [7:0] rd;
	logic [7:0] d;
	logic [7:0] sec;
	logic bot;
	logic prot;
	int span;
	logic [7:0] eraseOps [3] = '{8'hd8, 8'h52, 8'h20};

	serial_flash_status_protect serial_flash_status_protect_i (
		.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi), .wpN(wpN),
		.miso(miso), .misoEn(misoEn), .writeInProgress(writeInProgress),
		.statusLocked(statusLocked), .protectionError(protectionError));

	flash_host_model flash_host_model_i (
		.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso), .misoEn(misoEn));

	// system clock
	initial clk = 1'b0;
	always #2 clk = ~clk;

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic closeOut();
		$display("checks=%0d mismatches=%0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op);
		flash_host_model_i.xfer({op, 32'h0}, 8, rd);
		#40;
	endtask

	task automatic readReg(input logic [7:0] op, output logic [7:0] val);
		flash_host_model_i.xfer({op, 32'h0}, 16, val);
	endtask

	task automatic writeStatus(input logic [7:0] v);
		cmd(flash_protect_pkg::CMD_LATCH_SET);
		flash_host_model_i.xfer({flash_protect_pkg::CMD_STATUS_WRITE, v, 24'h0}, 16, rd);
		#40;
	endtask

	// waits out an internal cycle, bounded, then steps off the clock edge
	task automatic waitReady();
		int n;
		n = 0;
		while (writeInProgress !== 1'b0 && n < 600) begin
			@(negedge clk);
			n++;
		end
		if (n >= 600) begin
			failCount++;
			closeOut();
		end
		#1;
	endtask

	// expected protection of a sector for an anchor and protect code
	function automatic logic isProt(input logic b, input logic [3:0] bp, input logic [7:0] s);
		int w;
		if (bp == 4'h0) return 1'b0;
		if (bp >= 4'h9) return 1'b1;
		w = 1 << (bp - 1);
		return b ? (s < w) : (s >= 256 - w);
	endfunction

	// watchdog
	initial begin
		#400000;
		failCount++;
		closeOut();
	end

	// main sequence
	initial begin
		failCount = 0;
		checksDone = 0;
		rst = 1'b1;
		wpN = 1'b1;
		void'($urandom(53));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(negedge clk);
		#1;
		check({writeInProgress, statusLocked, protectionError}, 8'h00);
		readReg(flash_protect_pkg::CMD_STATUS_READ, rd);
		check(rd, 8'h00);
		readReg(flash_protect_pkg::CMD_FLAG_READ, rd);
		check(rd, 8'h80);
		flash_host_model_i.xfer({flash_protect_pkg::CMD_STATUS_WRITE, 8'h1c, 24'h0}, 16, rd);
		#40;
		check(writeInProgress, 1'b0);
		$display("test reset and latch done");

		// pin lock engages only with the lock bit and a low pin
		writeStatus(8'h80);
		waitReady();
		check(statusLocked, 1'b0);
		@(posedge clk) wpN <= 1'b0;
		repeat (6) @(negedge clk);
		#1;
		check(statusLocked, 1'b1);
		writeStatus(8'h1c);
		check(writeInProgress, 1'b0);
		readReg(flash_protect_pkg::CMD_STATUS_READ, rd);
		check(rd, 8'h80);
		@(posedge clk) wpN <= 1'b1;
		repeat (6) @(negedge clk);
		#1;
		check(statusLocked, 1'b0);
		writeStatus(8'h00);
		waitReady();
		readReg(flash_protect_pkg::CMD_STATUS_READ, rd);
		check(rd, 8'h00);
		$display("test lock done");

		// whole erase refused with protect code 0001, taken with none
		writeStatus(8'h04);
		waitReady();
		cmd(flash_protect_pkg::CMD_LATCH_SET);
		cmd(flash_protect_pkg::whole_array_erase_command);
		check(writeInProgress, 1'b0);
		readReg(flash_protect_pkg::CMD_STATUS_READ, rd);
		check(rd, 8'h04);
		writeStatus(8'h00);
		waitReady();
		cmd(flash_protect_pkg::CMD_LATCH_SET);
		cmd(flash_protect_pkg::whole_array_erase_command);
		check(writeInProgress, 1'b1);
		waitReady();
		$display("test whole erase done");

		// every protect code, random anchor, target on either side of the edge
		for (int c = 0; c < 16; c++) begin
			bot = 1'($urandom_range(0, 1));
			d = {1'b0, c[3], bot, c[2:0], 2'b00};
			writeStatus(d);
			check(writeInProgress, 1'b1);
			readReg(flash_protect_pkg::CMD_FLAG_READ, rd);
			check(rd, 8'h00);
			waitReady();
			readReg(flash_protect_pkg::CMD_STATUS_READ, rd);
			check(rd, d);
			span = (c == 0) ? 0 : (c >= 9) ? 256 : (1 << (c - 1));
			sec = 8'((bot ? span : 256 - span) - int'($urandom_range(0, 1)));
			prot = isProt(bot, 4'(c), sec);
			cmd(flash_protect_pkg::CMD_LATCH_SET);
			flash_host_model_i.xfer({eraseOps[$urandom_range(0, 2)], sec, 16'($urandom), 8'h0},
				32, rd);
			#40;
			check(protectionError, prot);
			check(writeInProgress, !prot);
			readReg(flash_protect_pkg::CMD_STATUS_READ, rd);
			if (prot) begin
				check(rd, d);
				readReg(flash_protect_pkg::CMD_FLAG_READ, rd);
				check(rd, 8'ha2);
				cmd(flash_protect_pkg::CMD_FLAG_CLEAR);
				check(protectionError, 1'b0);
			end else begin
				check(rd[0], 1'b1);
			end
			waitReady();
		end
		$display("test protect codes done");
		closeOut();
	end
endmodule
